//--- rtl/opcie_top.sv
// Operation
// - slow oscillator settled bit, read-only
// - mode bit: crystal or direct pin clock
// - slow settle count 256 to 16384 edges
// - start failure when edges miss window
// - two-bit slow crystal amplitude field
// - two-bit slow crystal drive field
// - slow control reset only at power-on
// - loop settled bit, read-only
// - loop settle count 128 to 16384 cycles
// - three-bit loop output range field
// - output equals reference times multiplier
// - two-bit loop input range field
// - loop reference select field
// - enable write needs unlock key
// - nine enable bits, one per event
// - run-loss to fault line, rest shared
// - read-only event flags, same positions
// - clear register: zero clears, one ignored
//
// The implementer's own choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module opcie_top #(
    parameter logic [31:0] START_WIN_SH_CYC = opcie_pkg::START_WIN_SH_CYC,
    parameter logic [31:0] START_WIN_LG_CYC = opcie_pkg::START_WIN_LG_CYC,
    parameter logic [31:0] RUN_LOSS_CYC     = opcie_pkg::RUN_LOSS_CYC
) (
    // clock, power-on reset and other reset sources
    input  wire logic        ref_clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        sys_rst_n_i,
    // avalon-mm slave
    input  wire logic [7:0]  address_i,
    input  wire logic        read_i,
    input  wire logic        write_i,
    input  wire logic [31:0] writedata_i,
    input  wire logic [3:0]  byteenable_i,
    output logic [31:0]      readdata_o,
    output logic             waitrequest_o,
    // oscillator clocks under watch
    input  wire logic        slow_ext_clk_i,
    input  wire logic        loop_clk_i,
    // events from neighbouring oscillator logic
    input  wire logic        fast_ext_run_loss_i,
    input  wire logic        fast_ext_start_failure_i,
    input  wire logic        slow_int_settled_event_i,
    input  wire logic        fast_ext_settled_event_i,
    input  wire logic        fast_int_settled_event_i,
    // slow oscillator analog controls
    output logic             slow_external_osc_en_o,
    output logic             slow_osc_bypass_o,
    output logic [1:0]       osc_amplitude_o,
    output logic [1:0]       osc_drive_strength_o,
    // loop analog controls
    output logic             loop_en_o,
    output logic [1:0]       loop_ref_sel_o,
    output logic [4:0]       loop_multiplier_o,
    output logic [1:0]       input_range_sel_o,
    output logic [2:0]       output_range_sel_o,
    output logic [3:0]       loop_debug_o,
    // interrupt lines
    output logic             fault_irq_o,
    output logic             clock_irq_o
);
    logic        sys_n;
    logic        ack_reg;
    logic [31:0] rdata_reg;
    logic [31:0] be_mask;
    logic        wr_go;
    logic [31:0] slow_reg;
    logic [31:0] slow_next;
    logic [31:0] loop_reg;
    logic [31:0] loop_next;
    logic [8:0]  ier_reg;
    logic [8:0]  flag_reg;
    logic [8:0]  flag_next;
    logic [2:0]  ctrl_reg;
    logic        fault_irq_reg;
    logic        clock_irq_reg;
    logic        slow_stable;
    logic        slow_fail;
    logic        slow_loss;
    logic        slow_stable_d_reg;
    logic        loop_stable;
    logic        loop_stable_d_reg;
    logic [8:0]  ev_vec;
    logic [14:0] slow_target;
    logic [14:0] loop_target;
    logic [31:0] slow_win;
    logic [31:0] rd_mux;

    // power-on reset reaches everything, other sources skip the slow reg
    assign sys_n = rst_n_i & sys_rst_n_i;

    // one wait state, then the request is taken
    assign waitrequest_o = (read_i | write_i) & ~ack_reg;
    assign wr_go         = write_i & ack_reg;
    assign be_mask = {{8{byteenable_i[3]}}, {8{byteenable_i[2]}},
                      {8{byteenable_i[1]}}, {8{byteenable_i[0]}}};

    always_ff @(posedge ref_clk_i or negedge sys_n) begin
        if (!sys_n) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= (read_i | write_i) & ~ack_reg;
        end
    end

    // merged write data for the byte lanes present
    assign slow_next = (slow_reg & ~be_mask) | (writedata_i & be_mask);
    assign loop_next = (loop_reg & ~be_mask) | (writedata_i & be_mask);

    // slow oscillator settings: only the power-on reset restores them
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            slow_reg <= opcie_pkg::SLOW_RST;
        end else if (wr_go && address_i == opcie_pkg::SLOW_OFS) begin
            slow_reg <= slow_next & 32'h0000_007f;
        end
    end

    // loop settings, debug bits kept writable as software may touch them
    always_ff @(posedge ref_clk_i or negedge sys_n) begin
        if (!sys_n) begin
            loop_reg <= opcie_pkg::LOOP_RST;
        end else if (wr_go && address_i == opcie_pkg::LOOP_OFS) begin
            loop_reg <= loop_next & 32'h000f_7fff;
        end
    end

    // interrupt enables, kept on a write whose key half is wrong
    always_ff @(posedge ref_clk_i or negedge sys_n) begin
        if (!sys_n) begin
            ier_reg <= opcie_pkg::IER_RST[8:0];
        end else if (wr_go && address_i == opcie_pkg::IER_OFS &&
                     byteenable_i[3:2] == 2'b11 &&
                     writedata_i[opcie_pkg::KEY_HI:opcie_pkg::KEY_LO] ==
                     opcie_pkg::KEY_VAL) begin
            ier_reg <= (writedata_i[8:0] & be_mask[8:0]) |
                       (ier_reg & ~be_mask[8:0]);
        end
    end

    // oscillator and security enables
    always_ff @(posedge ref_clk_i or negedge sys_n) begin
        if (!sys_n) begin
            ctrl_reg <= opcie_pkg::CTRL_RST;
        end else if (wr_go && address_i == opcie_pkg::CTRL_OFS &&
                     byteenable_i[0]) begin
            ctrl_reg <= writedata_i[2:0];
        end
    end

    // settle figures from the selection codes
    always_comb begin
        case (slow_reg[opcie_pkg::SE_WAIT_LO +: 2])
            2'h0:    slow_target = opcie_pkg::SE_CNT_0;
            2'h1:    slow_target = opcie_pkg::SE_CNT_1;
            2'h2:    slow_target = opcie_pkg::SE_CNT_2;
            default: slow_target = opcie_pkg::SE_CNT_3;
        endcase
        case (loop_reg[opcie_pkg::LP_WAIT_LO +: 3])
            3'h0:    loop_target = opcie_pkg::LP_CNT_0;
            3'h1:    loop_target = opcie_pkg::LP_CNT_1;
            3'h2:    loop_target = opcie_pkg::LP_CNT_2;
            3'h3:    loop_target = opcie_pkg::LP_CNT_3;
            3'h4:    loop_target = opcie_pkg::LP_CNT_4;
            3'h5:    loop_target = opcie_pkg::LP_CNT_5;
            default: loop_target = opcie_pkg::LP_CNT_7;
        endcase
        // longest code gets the long start window
        slow_win = (slow_reg[opcie_pkg::SE_WAIT_LO +: 2] == 2'h3) ?
                   START_WIN_LG_CYC : START_WIN_SH_CYC;
    end

    opcie_settle_cnt u_slow_cnt (
        .ref_clk_i    (ref_clk_i),
        .rst_n_i      (sys_n),
        .osc_clk_i    (slow_ext_clk_i),
        .enable_i     (ctrl_reg[opcie_pkg::CT_SE_EN]),
        .target_i     (slow_target),
        .watch_en_i   (ctrl_reg[opcie_pkg::CT_SE_CCS]),
        .win_cyc_i    (slow_win),
        .loss_cyc_i   (RUN_LOSS_CYC),
        .stable_o     (slow_stable),
        .start_fail_o (slow_fail),
        .run_loss_o   (slow_loss)
    );

    // the loop has no start watch, only its settled level
    opcie_settle_cnt u_loop_cnt (
        .ref_clk_i    (ref_clk_i),
        .rst_n_i      (sys_n),
        .osc_clk_i    (loop_clk_i),
        .enable_i     (ctrl_reg[opcie_pkg::CT_LP_EN]),
        .target_i     (loop_target),
        .watch_en_i   (1'b0),
        .win_cyc_i    (32'h0),
        .loss_cyc_i   (32'h0),
        .stable_o     (loop_stable),
        .start_fail_o (),
        .run_loss_o   ()
    );

    // settled levels delayed to find their rising edges
    always_ff @(posedge ref_clk_i or negedge sys_n) begin
        if (!sys_n) begin
            slow_stable_d_reg <= 1'b0;
            loop_stable_d_reg <= 1'b0;
        end else begin
            slow_stable_d_reg <= slow_stable;
            loop_stable_d_reg <= loop_stable;
        end
    end

    // events in flag order
    assign ev_vec = {fast_ext_run_loss_i, slow_loss,
                     fast_ext_start_failure_i, slow_fail,
                     slow_stable & ~slow_stable_d_reg,
                     slow_int_settled_event_i,
                     loop_stable & ~loop_stable_d_reg,
                     fast_ext_settled_event_i,
                     fast_int_settled_event_i};

    // a new event beats a clear in the same cycle
    always_comb begin
        flag_next = flag_reg;
        if (wr_go && address_i == opcie_pkg::CLR_OFS) begin
            flag_next = flag_reg & (writedata_i[8:0] | ~be_mask[8:0]);
        end
        flag_next = flag_next | ev_vec;
    end

    always_ff @(posedge ref_clk_i or negedge sys_n) begin
        if (!sys_n) begin
            flag_reg <= opcie_pkg::FLAG_RST;
        end else begin
            flag_reg <= flag_next;
        end
    end

    // run-loss goes to its own line, everything else is shared
    always_ff @(posedge ref_clk_i or negedge sys_n) begin
        if (!sys_n) begin
            fault_irq_reg <= 1'b0;
            clock_irq_reg <= 1'b0;
        end else begin
            fault_irq_reg <= |(flag_reg[8:7] & ier_reg[8:7]);
            clock_irq_reg <= |(flag_reg[6:0] & ier_reg[6:0]);
        end
    end

    // read mux, unmapped words read zero
    always_comb begin
        rd_mux = 32'h0;
        if (address_i == opcie_pkg::IER_OFS) begin
            rd_mux = {23'h0, ier_reg};
        end else if (address_i == opcie_pkg::FLAG_OFS) begin
            rd_mux = {23'h0, flag_reg};
        end else if (address_i == opcie_pkg::CLR_OFS) begin
            rd_mux = opcie_pkg::CLR_READ;
        end else if (address_i == opcie_pkg::SLOW_OFS) begin
            rd_mux = slow_reg;
            rd_mux[opcie_pkg::SE_STABLE] = slow_stable;
        end else if (address_i == opcie_pkg::LOOP_OFS) begin
            rd_mux = loop_reg;
            rd_mux[opcie_pkg::LP_STABLE] = loop_stable;
        end else if (address_i == opcie_pkg::CTRL_OFS) begin
            rd_mux = {29'h0, ctrl_reg};
        end
    end

    always_ff @(posedge ref_clk_i or negedge sys_n) begin
        if (!sys_n) begin
            rdata_reg <= 32'h0;
        end else if (read_i && !ack_reg) begin
            rdata_reg <= rd_mux;
        end
    end

    // outputs straight from the registers
    assign readdata_o             = rdata_reg;
    assign slow_external_osc_en_o = ctrl_reg[opcie_pkg::CT_SE_EN];
    assign slow_osc_bypass_o      = slow_reg[opcie_pkg::SE_MODE];
    assign osc_amplitude_o        = slow_reg[opcie_pkg::SE_AMP_LO +: 2];
    assign osc_drive_strength_o   = slow_reg[opcie_pkg::SE_DRV_LO +: 2];
    assign loop_en_o              = ctrl_reg[opcie_pkg::CT_LP_EN];
    assign loop_ref_sel_o         = loop_reg[opcie_pkg::LP_SRC_LO +: 2];
    assign loop_multiplier_o      = loop_reg[opcie_pkg::LP_MUL_LO +: 5];
    assign input_range_sel_o      = loop_reg[opcie_pkg::LP_IN_LO +: 2];
    assign output_range_sel_o     = loop_reg[opcie_pkg::LP_OUT_LO +: 3];
    assign loop_debug_o           = loop_reg[opcie_pkg::LP_DBG_LO +: 4];
    assign fault_irq_o            = fault_irq_reg;
    assign clock_irq_o            = clock_irq_reg;

    a_key_bad_ignored: assert property (
        @(posedge ref_clk_i) disable iff (!sys_n)
        (wr_go && address_i == opcie_pkg::IER_OFS &&
         writedata_i[31:16] != opcie_pkg::KEY_VAL) |=> $stable(ier_reg))
        else $error("enable write without key changed the enables");

    a_key_good_taken: assert property (
        @(posedge ref_clk_i) disable iff (!sys_n)
        (wr_go && address_i == opcie_pkg::IER_OFS && byteenable_i == 4'hf
         && writedata_i[31:16] == opcie_pkg::KEY_VAL)
        |=> ier_reg == $past(writedata_i[8:0]))
        else $error("keyed enable write not stored");

    a_flag_clear_set: assert property (
        @(posedge ref_clk_i) disable iff (!sys_n)
        (wr_go && address_i == opcie_pkg::CLR_OFS && byteenable_i == 4'hf)
        |=> flag_reg == (($past(flag_reg) & $past(writedata_i[8:0]))
                         | $past(ev_vec)))
        else $error("flag clear or event set wrong");

    a_fault_irq_line: assert property (
        @(posedge ref_clk_i) disable iff (!sys_n)
        (|(flag_reg[8:7] & ier_reg[8:7])) |=> fault_irq_o)
        else $error("fault line missing for run-loss");

    a_clock_irq_quiet: assert property (
        @(posedge ref_clk_i) disable iff (!sys_n)
        !(|(flag_reg[6:0] & ier_reg[6:0])) |=> !clock_irq_o)
        else $error("shared line high with no enabled flag");

    a_slow_read_status: assert property (
        @(posedge ref_clk_i) disable iff (!sys_n)
        (read_i && !ack_reg && address_i == opcie_pkg::SLOW_OFS)
        |=> readdata_o[15] == $past(slow_stable))
        else $error("slow settled bit reads wrong");

    a_slow_por_only: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        !sys_rst_n_i |=> $stable(slow_reg))
        else $error("slow control changed under a non power-on reset");

    a_loop_long_count: assert property (
        @(posedge ref_clk_i) disable iff (!sys_n)
        (loop_reg[14:12] == 3'h7) |-> loop_target == 15'h4000)
        else $error("loop settle code 7 not 16384");
endmodule : opcie_top
`default_nettype wire

//--- rtl/opcie_pkg.sv
// constants for the oscillator, loop and clock-event interrupt block
package opcie_pkg;
    // register byte offsets
    localparam logic [7:0] IER_OFS   = 8'h0c;
    localparam logic [7:0] FLAG_OFS  = 8'h10;
    localparam logic [7:0] CLR_OFS   = 8'h14;
    localparam logic [7:0] SLOW_OFS  = 8'h24;
    localparam logic [7:0] LOOP_OFS  = 8'h28;
    localparam logic [7:0] CTRL_OFS  = 8'h40;
    // reset values
    localparam logic [31:0] IER_RST  = 32'h0000_0000;
    localparam logic [8:0]  FLAG_RST = 9'h001;
    localparam logic [31:0] CLR_READ = 32'h0000_01ff;
    localparam logic [31:0] SLOW_RST = 32'h0000_002b;
    localparam logic [31:0] LOOP_RST = 32'h0005_3483;
    localparam logic [2:0]  CTRL_RST = 3'h0;
    // interrupt enable key
    localparam int          KEY_HI   = 31;
    localparam int          KEY_LO   = 16;
    localparam logic [15:0] KEY_VAL  = 16'h5a5a;
    localparam int          EV_MSB   = 8;
    // event bit positions
    localparam int EV_FE_LOSS  = 8;
    localparam int EV_SE_LOSS  = 7;
    localparam int EV_FE_FAIL  = 6;
    localparam int EV_SE_FAIL  = 5;
    localparam int EV_SE_RDY   = 4;
    localparam int EV_SI_RDY   = 3;
    localparam int EV_LOOP_RDY = 2;
    localparam int EV_FE_RDY   = 1;
    localparam int EV_FI_RDY   = 0;
    // slow oscillator control fields
    localparam int SE_STABLE   = 15;
    localparam int SE_MODE     = 6;
    localparam int SE_WAIT_LO  = 4;
    localparam int SE_AMP_LO   = 2;
    localparam int SE_DRV_LO   = 0;
    // loop control fields
    localparam int LP_DBG_LO   = 16;
    localparam int LP_STABLE   = 15;
    localparam int LP_WAIT_LO  = 12;
    localparam int LP_OUT_LO   = 9;
    localparam int LP_MUL_LO   = 4;
    localparam int LP_IN_LO    = 2;
    localparam int LP_SRC_LO   = 0;
    // own control register bits
    localparam int CT_SE_EN    = 0;
    localparam int CT_LP_EN    = 1;
    localparam int CT_SE_CCS   = 2;
    // settle counts in oscillator edges
    localparam logic [14:0] SE_CNT_0 = 15'h0100;
    localparam logic [14:0] SE_CNT_1 = 15'h0400;
    localparam logic [14:0] SE_CNT_2 = 15'h1000;
    localparam logic [14:0] SE_CNT_3 = 15'h4000;
    localparam logic [14:0] LP_CNT_0 = 15'h0080;
    localparam logic [14:0] LP_CNT_1 = 15'h0100;
    localparam logic [14:0] LP_CNT_2 = 15'h0200;
    localparam logic [14:0] LP_CNT_3 = 15'h0400;
    localparam logic [14:0] LP_CNT_4 = 15'h0800;
    localparam logic [14:0] LP_CNT_5 = 15'h1000;
    localparam logic [14:0] LP_CNT_7 = 15'h4000;
    // timing
    localparam longint CLK_HZ          = 200_000_000;
    localparam longint START_WIN_S_SH  = 1;
    localparam longint START_WIN_S_LG  = 2;
    localparam longint RUN_LOSS_US     = 100;
    localparam logic [31:0] START_WIN_SH_CYC = 32'(START_WIN_S_SH * CLK_HZ);
    localparam logic [31:0] START_WIN_LG_CYC = 32'(START_WIN_S_LG * CLK_HZ);
    localparam logic [31:0] RUN_LOSS_CYC =
        32'((RUN_LOSS_US * CLK_HZ) / 1_000_000);
endpackage : opcie_pkg

//--- rtl/opcie_settle_cnt.sv
// edge counter that judges oscillator settling, start failure and loss
`timescale 1ns/1ps
`default_nettype none
module opcie_settle_cnt (
    // clock and reset
    input  wire logic        ref_clk_i,
    input  wire logic        rst_n_i,
    // oscillator under watch and its settings
    input  wire logic        osc_clk_i,
    input  wire logic        enable_i,
    input  wire logic [14:0] target_i,
    input  wire logic        watch_en_i,
    input  wire logic [31:0] win_cyc_i,
    input  wire logic [31:0] loss_cyc_i,
    // results
    output logic             stable_o,
    output logic             start_fail_o,
    output logic             run_loss_o
);
    logic        osc_meta_reg;
    logic        osc_sync_reg;
    logic        osc_prev_reg;
    logic [14:0] cnt_reg;
    logic [31:0] timer_reg;
    logic        stable_reg;
    logic        failed_reg;
    logic        fail_reg;
    logic        loss_reg;
    logic        osc_edge;
    logic        hit;
    logic        win_hit;
    logic        loss_hit;

    // two-flop synchroniser, edge detect only after the second flop
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            osc_meta_reg <= 1'b0;
            osc_sync_reg <= 1'b0;
            osc_prev_reg <= 1'b0;
        end else begin
            osc_meta_reg <= osc_clk_i;
            osc_sync_reg <= osc_meta_reg;
            osc_prev_reg <= osc_sync_reg;
        end
    end

    assign osc_edge = osc_sync_reg & ~osc_prev_reg;
    assign hit      = !stable_reg && !failed_reg && osc_edge &&
                      (cnt_reg == target_i - 15'h0001);
    // settling on the window's last cycle wins over a start failure
    assign win_hit  = watch_en_i && !stable_reg && !failed_reg && !hit &&
                      (timer_reg == win_cyc_i - 32'h1);
    assign loss_hit = watch_en_i && stable_reg && !osc_edge &&
                      (timer_reg == loss_cyc_i - 32'h1);

    // edge count toward the selected settle figure
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_reg <= 15'h0000;
        end else if (!enable_i || loss_hit || hit) begin
            cnt_reg <= 15'h0000;
        end else if (!stable_reg && !failed_reg && osc_edge) begin
            cnt_reg <= cnt_reg + 15'h0001;
        end
    end

    // settled level, dropped again when the oscillator stops
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            stable_reg <= 1'b0;
        end else if (!enable_i || loss_hit) begin
            stable_reg <= 1'b0;
        end else if (hit) begin
            stable_reg <= 1'b1;
        end
    end

    // start window before settling, idle timer after it
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            timer_reg <= 32'h0;
        end else if (!enable_i || !watch_en_i || hit || loss_hit) begin
            timer_reg <= 32'h0;
        end else if (stable_reg && osc_edge) begin
            timer_reg <= 32'h0;
        end else if (!failed_reg && !win_hit) begin
            timer_reg <= timer_reg + 32'h1;
        end
    end

    // failure latch holds the counter until the oscillator is re-enabled
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            failed_reg <= 1'b0;
            fail_reg   <= 1'b0;
            loss_reg   <= 1'b0;
        end else begin
            failed_reg <= enable_i && (failed_reg || win_hit);
            fail_reg   <= enable_i && win_hit;
            loss_reg   <= enable_i && loss_hit;
        end
    end

    assign stable_o     = stable_reg;
    assign start_fail_o = fail_reg;
    assign run_loss_o   = loss_reg;

    a_settle_on_count: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        $rose(stable_reg) |-> $past(cnt_reg) == target_i - 15'h0001)
        else $error("settled without reaching the edge count");

    a_fail_in_window: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        $rose(fail_reg) |-> $past(timer_reg) == win_cyc_i - 32'h1
                            && !stable_reg)
        else $error("start failure outside the window end");
endmodule : opcie_settle_cnt
`default_nettype wire

//--- verif/tb_top.sv
// self-checking bench for the oscillator, loop and clock-event block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        ref_clk_i = 1'b0, rst_n_i = 1'b0, sys_rst_n_i = 1'b0;
    logic [7:0]  address_i = 8'h00;
    logic        read_i = 1'b0, write_i = 1'b0, osc_run = 1'b0;
    logic [31:0] writedata_i = 32'h0, readdata_o, q, d;
    logic        waitrequest_o, slow_ext_clk_i = 1'b0, loop_clk_i = 1'b0;
    logic [4:0]  evt = 5'h00;
    logic [1:0]  ref_sel, in_rng, osc_amplitude, drv;
    logic [2:0]  out_rng;
    logic [4:0]  mul;
    logic [3:0]  dbg;
    logic        bypass, se_en, lp_en, fault_irq_o, clock_irq_o;
    int          fail_count = 0, n_tests = 0, cyc = 0, seed = 32'hcf56816b;
    int          m_slow = 32'h2b, m_loop = 32'h53483, i;
    // short windows keep the run brief; no start window is exercised
    opcie_top #(.START_WIN_SH_CYC(32'd2000), .START_WIN_LG_CYC(32'd4000),
        .RUN_LOSS_CYC(32'd64)) u_opcie_top (.ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i), .sys_rst_n_i(sys_rst_n_i), .address_i(address_i),
        .read_i(read_i), .write_i(write_i), .writedata_i(writedata_i),
        .byteenable_i(4'hf), .readdata_o(readdata_o),
        .waitrequest_o(waitrequest_o), .slow_ext_clk_i(slow_ext_clk_i),
        .loop_clk_i(loop_clk_i), .fast_ext_run_loss_i(evt[4]),
        .fast_ext_start_failure_i(evt[3]), .slow_int_settled_event_i(evt[2]),
        .fast_ext_settled_event_i(evt[1]), .fast_int_settled_event_i(evt[0]),
        .slow_external_osc_en_o(se_en), .slow_osc_bypass_o(bypass),
        .osc_amplitude_o(osc_amplitude), .osc_drive_strength_o(drv), .loop_en_o(lp_en),
        .loop_ref_sel_o(ref_sel), .loop_multiplier_o(mul),
        .input_range_sel_o(in_rng), .output_range_sel_o(out_rng),
        .loop_debug_o(dbg), .fault_irq_o(fault_irq_o),
        .clock_irq_o(clock_irq_o));
    always #2.5 ref_clk_i = ~ref_clk_i;
    // oscillators stand still until enabled, slow one far below ref rate
    always @(posedge ref_clk_i) begin
        cyc <= cyc + 1;
        if (osc_run && cyc % 4 == 0) slow_ext_clk_i <= ~slow_ext_clk_i;
        if (osc_run && cyc % 2 == 0) loop_clk_i <= ~loop_clk_i;
        if (cyc == 20000) begin
            fail_count++;
            end_sim();
        end
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // one avalon access; held until waitrequest is seen low at a rise
    task bus(input logic wr, input logic [7:0] a, input logic [31:0] v);
        address_i   <= a;
        writedata_i <= v;
        write_i     <= wr;
        read_i      <= !wr;
        @(posedge ref_clk_i);
        while (waitrequest_o !== 1'b0) @(posedge ref_clk_i);
        q = readdata_o;
        write_i <= 1'b0;
        read_i  <= 1'b0;
        @(posedge ref_clk_i);
    endtask : bus
    task end_sim();
        $display("mismatches %0d of %0d compares", fail_count, n_tests);
        if (fail_count == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : end_sim
    initial begin
        repeat (6) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        sys_rst_n_i <= 1'b1;
        @(posedge ref_clk_i);
        bus(0, 8'h0c, 0); chk(q, 0);
        bus(0, 8'h24, 0); chk(q, 32'h2b);
        bus(0, 8'h28, 0); chk(q, 32'h53483);
        bus(0, 8'h14, 0); chk(q, 32'h1ff);
        bus(1, 8'h80, 1); bus(0, 8'h80, 0); chk(q, 0);
        // random slow and loop settings; multiplier kept legal
        for (i = 0; i < 6; i++) begin
            d = $random(seed);
            m_slow = d[6:0];
            m_loop = {12'h0, 4'h5, 1'b0, d[14:9], 5'(2 + d[20:16] % 11),
                d[3:0]};
            bus(1, 8'h24, d); bus(0, 8'h24, 0); chk(q, m_slow);
            chk({bypass, osc_amplitude, drv}, {m_slow[6], m_slow[3:0]});
            chk({osc_amplitude, drv}, m_slow[3:0]);
            bus(1, 8'h28, m_loop); bus(0, 8'h28, 0); chk(q, m_loop);
            chk({dbg, out_rng, mul, in_rng, ref_sel},
                {m_loop[19:16], m_loop[11:0]});
        end
        bus(1, 8'h0c, 32'h1234_01ff); bus(0, 8'h0c, 0); chk(q, 0);
        bus(1, 8'h0c, 32'h5a5a_0181); bus(0, 8'h0c, 0); chk(q, 32'h181);
        // all outside events at once, then each line and the clear
        @(posedge ref_clk_i) evt <= 5'h1f;
        @(posedge ref_clk_i) evt <= 5'h00;
        repeat (2) @(posedge ref_clk_i);
        chk({fault_irq_o, clock_irq_o}, 2'b11);
        bus(0, 8'h10, 0); chk(q, 32'h14b);
        bus(1, 8'h14, 32'hfffffeff);
        repeat (2) @(posedge ref_clk_i);
        chk({fault_irq_o, clock_irq_o}, 2'b01);
        bus(1, 8'h14, 0); bus(0, 8'h10, 0); chk(q, 0);
        chk(clock_irq_o, 0);
        // settling at the shortest codes of both counters
        bus(1, 8'h0c, 32'h5a5a_0014);
        bus(1, 8'h24, 32'h0b); bus(1, 8'h28, 32'h53483 & 32'hf8fff);
        bus(1, 8'h40, 3); osc_run <= 1'b1;
        repeat (100) @(posedge ref_clk_i);
        bus(0, 8'h24, 0); chk(q, 32'h0b);
        repeat (2300) @(posedge ref_clk_i);
        bus(0, 8'h24, 0); chk(q, 32'h800b);
        bus(0, 8'h28, 0); chk(q[15], 1);
        bus(0, 8'h10, 0); chk(q, 32'h014);
        chk({fault_irq_o, clock_irq_o}, 2'b01);
        // security on, then both oscillators stop: slow run-loss fires
        bus(1, 8'h0c, 32'h5a5a_0094); bus(1, 8'h40, 7); osc_run <= 1'b0;
        repeat (200) @(posedge ref_clk_i);
        bus(0, 8'h10, 0); chk(q, 32'h094);
        chk({fault_irq_o, clock_irq_o}, 2'b11);
        bus(0, 8'h24, 0); chk(q[15], 0);
        // a non power-on reset keeps the slow control setting only
        @(posedge ref_clk_i) sys_rst_n_i <= 1'b0;
        @(posedge ref_clk_i) sys_rst_n_i <= 1'b1;
        @(posedge ref_clk_i);
        bus(0, 8'h24, 0); chk(q & 32'h7f, 32'h0b);
        bus(0, 8'h28, 0); chk(q, 32'h53483);
        chk({se_en, lp_en}, 0);
        end_sim();
    end
endmodule : tb_top
`default_nettype wire
